// ==== hdl/spfc_ctrl.sv ====
// Self-programming flash control: control register, arming window, commands
`include "spfc_params.svh"
`default_nettype none
module spfc_ctrl import spfc_pkg::*; #(
  parameter int unsigned OP_CYCLES = `SPFC_OP_CYCLES,
  // Signature row bytes: values are arbitrary
  parameter logic [3:0][7:0] SIG_ROW = 32'h0c_0b_0a_09
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire spfc_bus_req_t i_bus,
  output logic [7:0] o_bus_rdata,
  input wire logic i_global_ie,
  input wire logic i_spm_valid,
  input wire logic i_lpm_valid,
  input wire logic [15:0] i_zptr,
  input wire logic [7:0] i_r0,
  input wire logic [7:0] i_r1,
  input wire logic [7:0] i_fuse_byte,
  input wire logic i_chip_erase,
  input wire logic [4:0] i_flash_rd_word,
  output logic o_lpm_hit,
  output logic o_lpm_done,
  output logic [7:0] o_lpm_data,
  output logic o_ready_irq,
  output logic o_live_section_busy,
  output logic o_cpu_halt,
  output logic o_op_busy,
  output spfc_flash_cmd_t o_flash_cmd,
  output logic [15:0] o_flash_wdata,
  output logic [7:0] o_lock_bits
);
  spfc_state_t state_r, state_nxt;
  spfc_ctl_t ctl_r, ctl_nxt;
  logic [1:0] arm_cnt_r, arm_cnt_nxt;
  logic [`SPFC_OP_CNT_W-1:0] op_cnt_r, op_cnt_nxt;
  logic halt_r;
  logic [7:0] lock_r;
  logic [7:0] rdata_r;
  logic [7:0] lpm_data_r;
  logic lpm_done_r;
  spfc_flash_cmd_t flash_cmd_r;
  logic buf_loading;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire logic [7:0] io_addr = `SPFC_OFF_DATA - `SPFC_IO_DELTA;
  wire logic addr_hit = i_bus.is_io ? (i_bus.addr == io_addr) : (i_bus.addr == `SPFC_OFF_DATA);
  wire logic wr_hit = i_bus.wr && addr_hit;
  wire logic rd_hit = i_bus.rd && addr_hit;
  wire logic [3:0] w_cmd = i_bus.wdata[`SPFC_CMD_HI:`SPFC_CMD_LO];
  wire logic w_sig = i_bus.wdata[`SPFC_B_SIG];
  // Store-enable with at most one command bit; signature only on its own
  wire logic pat_ok = i_bus.wdata[`SPFC_B_STORE_ENABLE] && $onehot0(w_cmd) && !(w_sig && (|w_cmd));
  wire logic cmd_take = wr_hit && pat_ok && (state_r == SPFC_IDLE);

  // ---------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------
  wire logic armed = (state_r == SPFC_ARMED);
  wire logic spm_take = i_spm_valid && armed;
  wire logic plain_store = !(ctl_r.sig || ctl_r.rre || ctl_r.blb || ctl_r.pgw || ctl_r.pge);
  wire logic page_op = ctl_r.pge || ctl_r.pgw;
  wire logic op_start = spm_take && (page_op || ctl_r.blb);
  wire logic [6:0] page_sel = i_zptr[`SPFC_Z_PAGE_HI:`SPFC_Z_PAGE_LO];
  wire logic [4:0] word_sel = i_zptr[`SPFC_Z_WORD_HI:`SPFC_Z_WORD_LO];
  wire logic halting = (page_sel >= `SPFC_HALT_PAGE_FIRST);
  wire logic op_done = (state_r == SPFC_BUSY) && (op_cnt_r == '0);
  wire logic window_lapse = armed && (arm_cnt_r == '0) && !i_spm_valid;
  wire logic buf_wr = spm_take && plain_store;
  wire logic buf_discard = spm_take && ctl_r.rre;
  wire logic lpm_in_win = armed && (arm_cnt_r >= `SPFC_LPM_MIN);
  wire logic lpm_hit = i_lpm_valid && lpm_in_win && (ctl_r.sig || ctl_r.blb);
  wire logic [7:0] sig_byte = SIG_ROW[i_zptr[`SPFC_Z_SIG_HI:`SPFC_Z_SIG_LO]];
  wire logic [7:0] lock_fuse = i_zptr[`SPFC_Z_BYTE] ? i_fuse_byte : lock_r;
  wire logic [7:0] lpm_sel = ctl_r.sig ? sig_byte : lock_fuse;
  wire logic [7:0] lock_new = lock_r & {`SPFC_LOCK_UNUSED, i_r0[`SPFC_LOCK_TOP:0]};
  wire logic [`SPFC_OP_CNT_W-1:0] op_load = `SPFC_OP_CNT_W'(OP_CYCLES - 1);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    ctl_nxt = ctl_r;
    arm_cnt_nxt = arm_cnt_r;
    op_cnt_nxt = op_cnt_r;
    if (wr_hit) begin
      ctl_nxt.ie = i_bus.wdata[`SPFC_B_IE];
    end
    unique case (state_r)
      SPFC_IDLE: begin
        if (cmd_take) begin
          ctl_nxt.sig = w_sig;
          {ctl_nxt.rre, ctl_nxt.blb, ctl_nxt.pgw, ctl_nxt.pge} = w_cmd;
          ctl_nxt.store_enable = 1'b1;
          arm_cnt_nxt = `SPFC_ARM_INIT;
          state_nxt = SPFC_ARMED;
        end
      end
      SPFC_ARMED: begin
        if (arm_cnt_r != '0) begin
          arm_cnt_nxt = arm_cnt_r - 2'h1;
        end
        if (op_start) begin
          op_cnt_nxt = op_load;
          state_nxt = SPFC_BUSY;
          if (page_op && !halting) begin
            ctl_nxt.busy = 1'b1;
          end
        end else if (spm_take || window_lapse) begin
          {ctl_nxt.sig, ctl_nxt.rre, ctl_nxt.blb, ctl_nxt.pgw, ctl_nxt.pge, ctl_nxt.store_enable} = '0;
          state_nxt = SPFC_IDLE;
          if (buf_wr || buf_discard) begin
            ctl_nxt.busy = 1'b0;
          end
        end
      end
      SPFC_BUSY: begin
        if (op_done) begin
          {ctl_nxt.sig, ctl_nxt.rre, ctl_nxt.blb, ctl_nxt.pgw, ctl_nxt.pge, ctl_nxt.store_enable} = '0;
          state_nxt = SPFC_IDLE;
        end else begin
          op_cnt_nxt = op_cnt_r - `SPFC_OP_CNT_W'(1);
        end
      end
      default: begin
        ctl_nxt = `SPFC_CTL_RESET;
        state_nxt = SPFC_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_r <= SPFC_IDLE;
      ctl_r <= `SPFC_CTL_RESET;
      arm_cnt_r <= '0;
      op_cnt_r <= '0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      ctl_r <= ctl_nxt;
      arm_cnt_r <= arm_cnt_nxt;
      op_cnt_r <= op_cnt_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      halt_r <= 1'b0;
      flash_cmd_r <= '0;
    end else if (i_ce) begin
      if (op_start && page_op && halting) begin
        halt_r <= 1'b1;
      end else if (op_done) begin
        halt_r <= 1'b0;
      end
      flash_cmd_r <= (op_start && page_op) ? {ctl_r.pge, ctl_r.pgw, page_sel} : '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      lock_r <= `SPFC_LOCK_RESET;
    end else if (i_ce) begin
      if (i_chip_erase) begin
        lock_r <= `SPFC_LOCK_RESET;
      end else if (op_start && ctl_r.blb) begin
        lock_r <= lock_new;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rdata_r <= `SPFC_RD_IDLE;
      lpm_data_r <= '0;
      lpm_done_r <= 1'b0;
    end else if (i_ce) begin
      rdata_r <= rd_hit ? ctl_r : `SPFC_RD_IDLE;
      lpm_done_r <= lpm_hit;
      if (lpm_hit) begin
        lpm_data_r <= lpm_sel;
      end
    end
  end

  // ---------------------------------------------------------------
  // Page buffer
  // ---------------------------------------------------------------
  spfc_page_buffer u_buf (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_wr(buf_wr),
    .i_widx(word_sel),
    .i_wdata({i_r1, i_r0}),
    .i_discard(buf_discard),
    .i_ridx(i_flash_rd_word),
    .o_rdata(o_flash_wdata),
    .o_loading(buf_loading)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_bus_rdata = rdata_r;
  assign o_lpm_hit = lpm_hit;
  assign o_lpm_done = lpm_done_r;
  assign o_lpm_data = lpm_data_r;
  assign o_ready_irq = ctl_r.ie && i_global_ie && !ctl_r.store_enable;
  assign o_live_section_busy = ctl_r.busy;
  assign o_cpu_halt = halt_r;
  assign o_op_busy = (state_r == SPFC_BUSY);
  assign o_flash_cmd = flash_cmd_r;
  assign o_lock_bits = lock_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst || !i_ce);

  a_arm_start: assert property (cmd_take |=> armed && arm_cnt_r == `SPFC_ARM_INIT)
    else $error("arming window did not start");
  a_arm_lapse: assert property (cmd_take ##1 (!i_spm_valid)[*4] |=> !ctl_r.store_enable && state_r == SPFC_IDLE)
    else $error("store-enable outlived four cycles");
  a_invalid_write: assert property (wr_hit && !pat_ok && state_r == SPFC_IDLE |=> state_r == SPFC_IDLE)
    else $error("invalid pattern armed a command");
  a_busy_set: assert property (op_start && page_op && !halting |=> o_live_section_busy && o_op_busy)
    else $error("live section busy not set");
  a_busy_clear: assert property (buf_wr || buf_discard |=> !o_live_section_busy)
    else $error("live section busy not cleared");
  a_store_enable_hold: assert property (o_op_busy |-> ctl_r.store_enable && !o_ready_irq)
    else $error("store-enable dropped during operation");
  a_irq_ready: assert property (ctl_r.ie && i_global_ie && state_r == SPFC_IDLE |-> o_ready_irq)
    else $error("ready interrupt missing");
  a_lock_mono: assert property (!i_chip_erase |=> ((lock_r & ~$past(lock_r)) == '0) && lock_r[7:6] == 2'h3)
    else $error("lock bit returned to one");
  a_lock_read: assert property (lpm_hit && ctl_r.blb && !i_zptr[0] |=> o_lpm_done && o_lpm_data == $past(lock_r))
    else $error("lock byte read wrong");
  a_sig_nop: assert property (spm_take && ctl_r.sig |=> !o_flash_cmd.erase && !o_flash_cmd.write && !o_op_busy)
    else $error("signature store had an effect");
  a_discard: assert property (buf_discard |=> !buf_loading)
    else $error("buffer not discarded");
  a_halt_end: assert property (op_done |=> !o_cpu_halt && !o_op_busy)
    else $error("halt outlived operation");

  c_page_write: cover property (op_start && ctl_r.pgw);
  c_lapse: cover property (window_lapse);
  c_lpm_read: cover property (lpm_hit);
endmodule : spfc_ctrl
`default_nettype wire

// ==== hdl/spfc_params.svh ====
// Constants of the self-programming flash control block
`ifndef SPFC_PARAMS_SVH
`define SPFC_PARAMS_SVH

// ---------------------------------------------------------------
// Register placement
// ---------------------------------------------------------------
`define SPFC_OFF_DATA 8'h57
`define SPFC_IO_DELTA 8'h20
`define SPFC_CTL_RESET 8'h00
`define SPFC_RD_IDLE 8'h00

// ---------------------------------------------------------------
// Control register bit positions
// ---------------------------------------------------------------
`define SPFC_B_IE 7
`define SPFC_B_SIG 5
`define SPFC_B_RRE 4
`define SPFC_B_STORE_ENABLE 0
`define SPFC_CMD_HI 4
`define SPFC_CMD_LO 1

// ---------------------------------------------------------------
// Z-pointer mapping, page geometry
// ---------------------------------------------------------------
`define SPFC_PC_TOP 11
`define SPFC_WORD_TOP 4
`define SPFC_Z_PAGE_HI 12
`define SPFC_Z_PAGE_LO 6
`define SPFC_Z_WORD_HI 5
`define SPFC_Z_WORD_LO 1
`define SPFC_Z_BYTE 0
`define SPFC_Z_SIG_HI 2
`define SPFC_Z_SIG_LO 1
`define SPFC_PAGE_WORDS 32
`define SPFC_HALT_PAGE_FIRST 7'h70

// ---------------------------------------------------------------
// Lock byte
// ---------------------------------------------------------------
`define SPFC_LOCK_RESET 8'hff
`define SPFC_LOCK_UNUSED 2'h3
`define SPFC_LOCK_TOP 5
`define SPFC_BUF_BLANK 16'hffff

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SPFC_ARM_INIT 2'h3
`define SPFC_LPM_MIN 2'h1
`define SPFC_CLK_PERIOD_NS 20
`define SPFC_OP_TIME_NS 3200000
`define SPFC_OP_CYCLES ((`SPFC_OP_TIME_NS + `SPFC_CLK_PERIOD_NS - 1) / `SPFC_CLK_PERIOD_NS)
`define SPFC_OP_CNT_W 18

`endif

// ==== hdl/spfc_pkg.sv ====
// Types of the self-programming flash control block
`default_nettype none
package spfc_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic is_io;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spfc_bus_req_t;

  typedef struct packed {
    logic ie;
    logic busy;
    logic sig;
    logic rre;
    logic blb;
    logic pgw;
    logic pge;
    logic store_enable;
  } spfc_ctl_t;

  typedef struct packed {
    logic erase;
    logic write;
    logic [6:0] page;
  } spfc_flash_cmd_t;

  typedef enum logic [1:0] {
    SPFC_IDLE = 2'b00,
    SPFC_ARMED = 2'b01,
    SPFC_BUSY = 2'b11
  } spfc_state_t;
endpackage : spfc_pkg
`default_nettype wire

// ==== hdl/spfc_page_buffer.sv ====
// Temporary page buffer with per-word fill marks
`include "spfc_params.svh"
`default_nettype none
module spfc_page_buffer import spfc_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [4:0] i_widx,
  input wire logic [15:0] i_wdata,
  input wire logic i_discard,
  input wire logic [4:0] i_ridx,
  output logic [15:0] o_rdata,
  output logic o_loading
);
  logic [15:0] mem [`SPFC_PAGE_WORDS];
  logic [`SPFC_PAGE_WORDS-1:0] filled_r;
  logic [15:0] rdata_r;

  // ---------------------------------------------------------------
  // Per-word fill marks; a discard drops every word
  // ---------------------------------------------------------------
  for (genvar g = 0; g < `SPFC_PAGE_WORDS; g++) begin : g_word
    wire logic hit = i_wr && (i_widx == 5'(g));
    always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
        filled_r[g] <= 1'b0;
      end else if (i_ce) begin
        filled_r[g] <= i_discard ? 1'b0 : (filled_r[g] | hit);
      end
    end
    always_ff @(posedge i_core_clk) begin
      if (i_ce && hit) begin
        mem[g] <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rdata_r <= `SPFC_BUF_BLANK;
    end else if (i_ce) begin
      rdata_r <= filled_r[i_ridx] ? mem[i_ridx] : `SPFC_BUF_BLANK;
    end
  end

  assign o_rdata = rdata_r;
  assign o_loading = |filled_r;
endmodule : spfc_page_buffer
`default_nettype wire

// ==== dv/spfc_cpu_model.sv ====
// CPU core model issuing register, store and load accesses
`default_nettype none
module spfc_cpu_model import spfc_pkg::*; (
  input wire logic i_core_clk,
  output spfc_bus_req_t o_bus,
  output logic o_spm,
  output logic o_lpm,
  output logic [15:0] o_zptr,
  output logic [7:0] o_r0,
  output logic [7:0] o_r1
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_bus = '0;
    o_spm = 1'b0;
    o_lpm = 1'b0;
    o_zptr = '0;
    {o_r1, o_r0} = '0;
  end

  // ------------------------------------------------------------
  // Accesses: driven after a falling edge, held one full cycle
  // ------------------------------------------------------------
  task automatic acc(input logic wr, input logic io, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_bus <= '{rd: !wr, wr: wr, is_io: io, addr: a, wdata: d};
    @(negedge i_core_clk);
    // Released strobes drop to zero; the other lines show the inverse, never the stale value
    o_bus <= '{rd: 1'b0, wr: 1'b0, is_io: !io, addr: ~a, wdata: ~d};
  endtask : acc

  task automatic spm(input int k, input logic [15:0] z, input logic [15:0] w);
    repeat (k) @(negedge i_core_clk);
    o_spm <= 1'b1;
    o_zptr <= z;
    {o_r1, o_r0} <= w;
    @(negedge i_core_clk);
    o_spm <= 1'b0;
    o_zptr <= ~z;
    {o_r1, o_r0} <= ~w;
  endtask : spm

  task automatic lpm(input int k, input logic [15:0] z);
    repeat (k) @(negedge i_core_clk);
    o_lpm <= 1'b1;
    o_zptr <= z;
    @(negedge i_core_clk);
    o_lpm <= 1'b0;
    o_zptr <= ~z;
  endtask : lpm
endmodule : spfc_cpu_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the self-programming flash control block
`include "spfc_params.svh"
`default_nettype none
module tb_top import spfc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary signature bytes
  localparam logic [31:0] SIG = 32'h44332211;
  localparam logic [7:0] BAD [5] = '{8'h07, 8'h02, 8'h31, 8'h19, 8'h2b};
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic gie = 1'b0;
  logic chip_erase = 1'b0;
  logic ce = 1'b1;
  logic rd_d = 1'b0;
  logic hit_seen = 1'b0;
  logic [4:0] rd_word = '0;
  logic [7:0] fuse = 8'h00;
  spfc_bus_req_t bus;
  logic spm, lpm, lpm_hit, lpm_done, irq, busy, halt, opb;
  logic [15:0] z, w, d, fwdata;
  logic [7:0] r0, r1, rdata, lpm_data, lock, v;
  spfc_flash_cmd_t fcmd;
  logic [7:0] exp_q [$];
  int fail_count = 0;
  int check_count = 0;

  always #10 core_clk = ~core_clk;

  spfc_cpu_model i_spfc_cpu_model (.i_core_clk(core_clk), .o_bus(bus), .o_spm(spm), .o_lpm(lpm),
    .o_zptr(z), .o_r0(r0), .o_r1(r1));

  spfc_ctrl #(.OP_CYCLES(8), .SIG_ROW(SIG)) i_spfc_ctrl (.i_core_clk(core_clk), .i_srst(srst),
    .i_ce(ce), .i_bus(bus), .o_bus_rdata(rdata), .i_global_ie(gie), .i_spm_valid(spm),
    .i_lpm_valid(lpm), .i_zptr(z), .i_r0(r0), .i_r1(r1), .i_fuse_byte(fuse),
    .i_chip_erase(chip_erase), .i_flash_rd_word(rd_word), .o_lpm_hit(lpm_hit),
    .o_lpm_done(lpm_done), .o_lpm_data(lpm_data), .o_ready_irq(irq), .o_live_section_busy(busy),
    .o_cpu_halt(halt), .o_op_busy(opb), .o_flash_cmd(fcmd), .o_flash_wdata(fwdata), .o_lock_bits(lock));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  function automatic logic [7:0] pop();
    if (exp_q.size() == 0) return 8'hxx;
    return exp_q.pop_front();
  endfunction : pop

  task automatic cmd(input logic [7:0] c);
    i_spfc_cpu_model.acc(1'b1, 1'b0, `SPFC_OFF_DATA, c);
  endtask : cmd

  task automatic rdx(input logic io, input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_spfc_cpu_model.acc(1'b0, io, a, 8'h00);
  endtask : rdx

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  always @(posedge core_clk) begin
    rd_d <= bus.rd;
    if (lpm) hit_seen <= lpm_hit;
  end

  always @(negedge core_clk) begin
    if (rd_d) chk("ctl_read", 16'(rdata), 16'(pop()));
    if (lpm_done) chk("lpm_data", 16'(lpm_data), 16'(pop()));
  end

  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h0cd5faf3));
    idle(6);
    srst <= 1'b0;
    rdx(1'b0, 8'h57, 8'h00);
    chk("lock_reset", 16'(lock), 16'h00ff);
    gie <= 1'b1;
    i_spfc_cpu_model.acc(1'b1, 1'b1, 8'h37, 8'h80);
    rdx(1'b0, 8'h57, 8'h80);
    rdx(1'b1, 8'h57, 8'h00);
    rdx(1'b0, 8'h37, 8'h00);
    chk("irq", 16'(irq), 16'h0001);
    cmd(8'h81);
    chk("irq_armed", 16'(irq), 16'h0000);
    idle(5);
    chk("irq_lapsed", 16'(irq), 16'h0001);
    rdx(1'b0, 8'h57, 8'h80);
    for (int i = 0; i < 5; i++) begin
      cmd(BAD[i]);
      rdx(1'b0, 8'h57, 8'h00);
    end
    // Buffer fill at the last cycle of the window, pointer LSB set
    w = 16'($urandom_range(31));
    d = 16'($urandom);
    cmd(8'h01);
    i_spfc_cpu_model.spm(3, {3'($urandom), 7'h05, w[4:0], 1'b1}, d);
    chk("fcmd_fill", 16'(fcmd), 16'h0000);
    rd_word <= w[4:0];
    idle(1);
    chk("fill_word", fwdata, d);
    rdx(1'b0, 8'h57, 8'h00);
    cmd(8'h03);
    i_spfc_cpu_model.spm(0, {3'($urandom), 7'h12, 6'h00}, 16'($urandom));
    chk("fcmd_erase", 16'(fcmd), {7'h0, 2'b10, 7'h12});
    chk("busy_set", 16'(busy), 16'h0001);
    chk("op_busy", 16'(opb), 16'h0001);
    rdx(1'b0, 8'h57, 8'h43);
    idle(12);
    rdx(1'b0, 8'h57, 8'h40);
    cmd(8'h11);
    i_spfc_cpu_model.spm(0, 16'h0000, 16'h0000);
    chk("busy_rre", 16'(busy), 16'h0000);
    idle(1);
    chk("discard", fwdata, 16'hffff);
    cmd(8'h05);
    i_spfc_cpu_model.spm(4, 16'h1c00, 16'h1234);
    chk("fcmd_late", 16'(fcmd), 16'h0000);
    rdx(1'b0, 8'h57, 8'h00);
    cmd(8'h05);
    i_spfc_cpu_model.spm(3, 16'h1c00, 16'($urandom));
    chk("fcmd_write", 16'(fcmd), {7'h0, 2'b01, 7'h70});
    chk("halt_set", 16'(halt), 16'h0001);
    chk("busy_halt", 16'(busy), 16'h0000);
    idle(12);
    chk("halt_clr", 16'(halt), 16'h0000);
    cmd(8'h03);
    i_spfc_cpu_model.spm(0, 16'h0040, 16'h0000);
    idle(12);
    cmd(8'h01);
    i_spfc_cpu_model.spm(0, 16'h0002, 16'($urandom));
    chk("busy_load", 16'(busy), 16'h0000);
    fuse <= 8'($urandom);
    cmd(8'h09);
    exp_q.push_back(8'hff);
    i_spfc_cpu_model.lpm(0, 16'he000);
    chk("hit_lock", 16'(hit_seen), 16'h0001);
    exp_q.push_back(fuse);
    i_spfc_cpu_model.lpm(1, 16'h0001);
    chk("hit_fuse", 16'(hit_seen), 16'h0001);
    idle(5);
    cmd(8'h09);
    i_spfc_cpu_model.lpm(3, 16'h0000);
    chk("hit_late", 16'(hit_seen), 16'h0000);
    idle(3);
    v = 8'($urandom);
    cmd(8'h09);
    i_spfc_cpu_model.spm(0, 16'($urandom) & 16'hfffe, {8'($urandom), v});
    idle(12);
    chk("lock_set", 16'(lock), {8'h00, 2'b11, v[5:0]});
    chip_erase <= 1'b1;
    idle(1);
    chip_erase <= 1'b0;
    idle(1);
    chk("lock_erase", 16'(lock), 16'h00ff);
    for (int i = 0; i < 4; i++) begin
      cmd(8'h21);
      exp_q.push_back(SIG[i*8 +: 8]);
      i_spfc_cpu_model.lpm(2, {13'h0, 2'(i), 1'b0});
      idle(4);
    end
    cmd(8'h21);
    i_spfc_cpu_model.spm(0, 16'h0080, 16'h5555);
    chk("fcmd_sig", 16'(fcmd), 16'h0000);
    rdx(1'b0, 8'h57, 8'h00);
    // Clock enable low freezes the arming window; the store still lands afterwards
    cmd(8'h01);
    ce <= 1'b0;
    idle(6);
    ce <= 1'b1;
    i_spfc_cpu_model.spm(0, 16'h0006, 16'h5a5a);
    rd_word <= 5'h03;
    idle(1);
    chk("ce_freeze", fwdata, 16'h5a5a);
    idle(2);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
